// ==== inc/seq_consts.svh ====
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

// clock
`define CLK_PERIOD_NS 25

// supply step delay, kept between 5 us and 10 us
`define SUPPLY_STEP_NS 5000
`define SUPPLY_STEP_CYC ((`SUPPLY_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HARD_RESET_NS 1000000
`define HARD_RESET_CYC ((`HARD_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_WAIT_CYC 150000
`define PLL_LOCK_NS 1000000
`define PLL_LOCK_CYC ((`PLL_LOCK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OFF_HOLD_MS 100
`define OFF_HOLD_CYC ((`OFF_HOLD_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// sensor register
`define MODE_CTRL_ADDR 16'h301A
`define STREAM_ON_BIT 2
`define MODE_BASE_RST 16'h0000

// apb map, byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_SER_ADDR 12'h008
`define OFS_SER_DATA 12'h00C
`define OFS_CMD 12'h010
`define OFS_MODE_BASE 12'h014
`define OFS_STBY_WAIT 12'h018

// field positions
`define CTRL_POWER_BIT 0
`define CTRL_STREAM_BIT 1
`define CMD_SER_GO_BIT 0
`define CMD_CFG_DONE_BIT 1
`define STATUS_BUSY_BIT 8
`define STATUS_STREAM_BIT 9
`define STBY_WAIT_RST 23'h0F4240

`define TMR_W 23

`endif

// ==== inc/seq_pkg.sv ====
package seq_pkg;
    typedef enum logic [4:0] {
        ST_OFF_HOLD,
        ST_OFF,
        ST_UP_ANA,
        ST_UP_CORE,
        ST_UP_IO,
        ST_WAIT_STABLE,
        ST_RST_HOLD,
        ST_INIT_WAIT,
        ST_CONFIG,
        ST_LOCK_WAIT,
        ST_READY,
        ST_STREAM_ON_WR,
        ST_STREAMING,
        ST_STREAM_OFF_WR,
        ST_STBY_WAIT,
        ST_DN_IO,
        ST_DN_CORE,
        ST_DN_ANA,
        ST_DN_PLL
    } state_t;
endpackage : seq_pkg

// ==== hdl/delay_timer.sv ====
`timescale 1ns/1ps
`include "seq_consts.svh"

module delay_timer (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // control
    input wire logic load_i,
    input wire logic [`TMR_W-1:0] val_i,
    output logic done_o
);
    typedef struct packed {
        logic [`TMR_W-1:0] cnt;
        logic done;
    } tmr_t;

    tmr_t tmr_reg;
    tmr_t tmr_next;

    always_comb begin
        tmr_next = tmr_reg;
        if (load_i) begin
            tmr_next.cnt = val_i;
            tmr_next.done = (val_i == '0);
        end else if (tmr_reg.cnt != '0) begin
            tmr_next.cnt = tmr_reg.cnt - `TMR_W'(1);
            tmr_next.done = (tmr_reg.cnt == `TMR_W'(1));
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tmr_reg <= '{cnt: '0, done: 1'b1};
        end else begin
            tmr_reg <= tmr_next;
        end
    end

    assign done_o = tmr_reg.done;
endmodule : delay_timer

// ==== hdl/sensor_power_reset_sequencer.sv ====
// What this block does
// - raise pll, analog/pixel, core, io supplies in order, 0 to 10 us apart
// - pll supply is always raised first, never after the others
// - leave at least 5 us between core and io supply enables
// - start the sensor reference clock only once supplies report stable
// - keep hard reset low at least 1 ms after supplies settle
// - wait 150,000 reference clocks after reset release before configuring
// - after configuration wait at least 1 ms for pll lock before streaming
// - stream start writes mode control bit 2 to one, stop writes zero
// - clear streaming before removing any supply
// - drop io, core, analog/pixel, then pll, each no earlier than previous
// - keep supplies off at least 100 ms before the next power-up
`timescale 1ns/1ps
`include "seq_consts.svh"

module sensor_power_reset_sequencer
    import seq_pkg::*;
#(
    parameter int unsigned HARD_RESET_CYC = `HARD_RESET_CYC,
    parameter int unsigned INIT_WAIT_CYC = `INIT_WAIT_CYC,
    parameter int unsigned PLL_LOCK_CYC = `PLL_LOCK_CYC,
    parameter int unsigned OFF_HOLD_CYC = `OFF_HOLD_CYC
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // supply enables and power good
    output logic pll_supply_en_o,
    output logic pixel_supply_en_o,
    output logic core_supply_en_o,
    output logic io_supply_en_o,
    input wire logic supplies_stable_i,
    // sensor clock and reset
    output logic ref_clock_in_en_o,
    output logic sensor_reset_n_o,
    // serial register write port
    output logic ser_req_o,
    output logic [15:0] ser_addr_o,
    output logic [15:0] ser_data_o,
    input wire logic ser_ack_i
);
    typedef struct packed {
        state_t state;
        logic tmr_load;
        logic [`TMR_W-1:0] tmr_val;
        logic pll_en;
        logic pix_en;
        logic core_en;
        logic io_en;
        logic clk_en;
        logic rst_n;
        logic ser_req;
        logic [15:0] ser_addr;
        logic [15:0] ser_data;
        logic power_req;
        logic stream_req;
        logic cfg_done;
        logic [15:0] sw_addr;
        logic [15:0] sw_data;
        logic [15:0] mode_base;
        logic [`TMR_W-1:0] stby_wait;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } seq_t;

    localparam seq_t SEQ_RST = '{
        state: ST_OFF_HOLD,
        tmr_load: 1'b1,
        tmr_val: `TMR_W'(OFF_HOLD_CYC),
        rst_n: 1'b0,
        mode_base: `MODE_BASE_RST,
        stby_wait: `STBY_WAIT_RST,
        default: '0
    };

    seq_t seq_reg;
    seq_t seq_next;
    logic tmr_done;

    delay_timer u_timer (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .load_i(seq_reg.tmr_load),
        .val_i(seq_reg.tmr_val),
        .done_o(tmr_done)
    );

    // timer output is stale in the cycle its load is still pending
    logic elapsed;
    assign elapsed = tmr_done && !seq_reg.tmr_load;

    logic apb_take;
    assign apb_take = psel_i && penable_i && !seq_reg.pready;

    logic ser_allowed;
    always_comb begin
        case (seq_reg.state)
            ST_CONFIG, ST_LOCK_WAIT, ST_READY, ST_STREAMING, ST_STBY_WAIT: ser_allowed = 1'b1;
            default: ser_allowed = 1'b0;
        endcase
    end

    logic [15:0] stream_on_word;
    logic [15:0] stream_off_word;
    assign stream_on_word = seq_reg.mode_base | (16'h0001 << `STREAM_ON_BIT);
    assign stream_off_word = seq_reg.mode_base & ~(16'h0001 << `STREAM_ON_BIT);

    always_comb begin
        logic seq_launch;
        logic ser_go;
        logic cfg_go;
        seq_launch = 1'b0;
        ser_go = 1'b0;
        cfg_go = 1'b0;
        seq_next = seq_reg;
        seq_next.tmr_load = 1'b0;

        // apb register access, answered one cycle into the access phase
        seq_next.pready = apb_take;
        seq_next.pslverr = 1'b0;
        if (apb_take) begin
            seq_next.prdata = '0;
            case (paddr_i)
                `OFS_CTRL: begin
                    if (pwrite_i) begin
                        seq_next.power_req = pwdata_i[`CTRL_POWER_BIT];
                        seq_next.stream_req = pwdata_i[`CTRL_STREAM_BIT];
                    end else begin
                        seq_next.prdata[`CTRL_POWER_BIT] = seq_reg.power_req;
                        seq_next.prdata[`CTRL_STREAM_BIT] = seq_reg.stream_req;
                    end
                end
                `OFS_STATUS: begin
                    seq_next.prdata[4:0] = seq_reg.state;
                    seq_next.prdata[`STATUS_BUSY_BIT] = seq_reg.ser_req;
                    seq_next.prdata[`STATUS_STREAM_BIT] = (seq_reg.state == ST_STREAMING);
                end
                `OFS_SER_ADDR: begin
                    if (pwrite_i) begin
                        seq_next.sw_addr = pwdata_i[15:0];
                    end
                    seq_next.prdata[15:0] = seq_reg.sw_addr;
                end
                `OFS_SER_DATA: begin
                    if (pwrite_i) begin
                        seq_next.sw_data = pwdata_i[15:0];
                    end
                    seq_next.prdata[15:0] = seq_reg.sw_data;
                end
                `OFS_CMD: begin
                    ser_go = pwrite_i && pwdata_i[`CMD_SER_GO_BIT];
                    cfg_go = pwrite_i && pwdata_i[`CMD_CFG_DONE_BIT];
                end
                `OFS_MODE_BASE: begin
                    if (pwrite_i) begin
                        seq_next.mode_base = pwdata_i[15:0];
                    end
                    seq_next.prdata[15:0] = seq_reg.mode_base;
                end
                `OFS_STBY_WAIT: begin
                    if (pwrite_i) begin
                        seq_next.stby_wait = pwdata_i[`TMR_W-1:0];
                    end
                    seq_next.prdata[`TMR_W-1:0] = seq_reg.stby_wait;
                end
                default: begin
                    seq_next.pslverr = 1'b1;
                end
            endcase
        end

        // serial port: request held until the sensor side acknowledges
        if (seq_reg.ser_req && ser_ack_i) begin
            seq_next.ser_req = 1'b0;
        end

        // config done only counts once the sensor is out of initialisation
        if (cfg_go && seq_reg.state == ST_CONFIG) begin
            seq_next.cfg_done = 1'b1;
        end

        case (seq_reg.state)
            ST_OFF_HOLD: begin
                if (elapsed) begin
                    seq_next.state = ST_OFF;
                end
            end
            ST_OFF: begin
                if (seq_reg.power_req) begin
                    seq_next.pll_en = 1'b1;
                    seq_next.tmr_load = 1'b1;
                    seq_next.tmr_val = `TMR_W'(`SUPPLY_STEP_CYC);
                    seq_next.state = ST_UP_ANA;
                end
            end
            ST_UP_ANA: begin
                if (elapsed) begin
                    seq_next.pix_en = 1'b1;
                    seq_next.tmr_load = 1'b1;
                    seq_next.tmr_val = `TMR_W'(`SUPPLY_STEP_CYC);
                    seq_next.state = ST_UP_CORE;
                end
            end
            ST_UP_CORE: begin
                if (elapsed) begin
                    seq_next.core_en = 1'b1;
                    seq_next.tmr_load = 1'b1;
                    seq_next.tmr_val = `TMR_W'(`SUPPLY_STEP_CYC);
                    seq_next.state = ST_UP_IO;
                end
            end
            ST_UP_IO: begin
                if (elapsed) begin
                    seq_next.io_en = 1'b1;
                    seq_next.state = ST_WAIT_STABLE;
                end
            end
            ST_WAIT_STABLE: begin
                if (!seq_reg.power_req) begin
                    seq_next.state = ST_DN_IO;
                end else if (supplies_stable_i) begin
                    seq_next.clk_en = 1'b1;
                    seq_next.tmr_load = 1'b1;
                    seq_next.tmr_val = `TMR_W'(HARD_RESET_CYC);
                    seq_next.state = ST_RST_HOLD;
                end
            end
            ST_RST_HOLD: begin
                if (elapsed) begin
                    seq_next.rst_n = 1'b1;
                    seq_next.tmr_load = 1'b1;
                    seq_next.tmr_val = `TMR_W'(INIT_WAIT_CYC);
                    seq_next.state = ST_INIT_WAIT;
                end
            end
            ST_INIT_WAIT: begin
                if (elapsed) begin
                    seq_next.cfg_done = 1'b0;
                    seq_next.state = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                if (!seq_reg.power_req) begin
                    seq_next.state = ST_DN_IO;
                end else if (seq_reg.cfg_done && !seq_reg.ser_req) begin
                    seq_next.tmr_load = 1'b1;
                    seq_next.tmr_val = `TMR_W'(PLL_LOCK_CYC);
                    seq_next.state = ST_LOCK_WAIT;
                end
            end
            ST_LOCK_WAIT: begin
                if (elapsed) begin
                    seq_next.state = ST_READY;
                end
            end
            ST_READY: begin
                if (!seq_reg.power_req) begin
                    seq_next.state = ST_DN_IO;
                end else if (seq_reg.stream_req && !seq_reg.ser_req) begin
                    seq_launch = 1'b1;
                    seq_next.ser_req = 1'b1;
                    seq_next.ser_addr = `MODE_CTRL_ADDR;
                    seq_next.ser_data = stream_on_word;
                    seq_next.state = ST_STREAM_ON_WR;
                end
            end
            ST_STREAM_ON_WR: begin
                if (seq_reg.ser_req && ser_ack_i) begin
                    seq_next.state = ST_STREAMING;
                end
            end
            ST_STREAMING: begin
                // power-down also passes through the stop write first
                if ((!seq_reg.stream_req || !seq_reg.power_req) && !seq_reg.ser_req) begin
                    seq_launch = 1'b1;
                    seq_next.ser_req = 1'b1;
                    seq_next.ser_addr = `MODE_CTRL_ADDR;
                    seq_next.ser_data = stream_off_word;
                    seq_next.state = ST_STREAM_OFF_WR;
                end
            end
            ST_STREAM_OFF_WR: begin
                if (seq_reg.ser_req && ser_ack_i) begin
                    seq_next.tmr_load = 1'b1;
                    seq_next.tmr_val = seq_reg.stby_wait;
                    seq_next.state = ST_STBY_WAIT;
                end
            end
            ST_STBY_WAIT: begin
                // the sensor finishes its row or frame; no pin shows it
                if (elapsed && !seq_reg.ser_req) begin
                    seq_next.state = seq_reg.power_req ? ST_READY : ST_DN_IO;
                end
            end
            ST_DN_IO: begin
                seq_next.rst_n = 1'b0;
                seq_next.clk_en = 1'b0;
                seq_next.io_en = 1'b0;
                seq_next.tmr_load = 1'b1;
                seq_next.tmr_val = `TMR_W'(`SUPPLY_STEP_CYC);
                seq_next.state = ST_DN_CORE;
            end
            ST_DN_CORE: begin
                if (elapsed) begin
                    seq_next.core_en = 1'b0;
                    seq_next.tmr_load = 1'b1;
                    seq_next.tmr_val = `TMR_W'(`SUPPLY_STEP_CYC);
                    seq_next.state = ST_DN_ANA;
                end
            end
            ST_DN_ANA: begin
                if (elapsed) begin
                    seq_next.pix_en = 1'b0;
                    seq_next.tmr_load = 1'b1;
                    seq_next.tmr_val = `TMR_W'(`SUPPLY_STEP_CYC);
                    seq_next.state = ST_DN_PLL;
                end
            end
            ST_DN_PLL: begin
                if (elapsed) begin
                    seq_next.pll_en = 1'b0;
                    seq_next.tmr_load = 1'b1;
                    seq_next.tmr_val = `TMR_W'(OFF_HOLD_CYC);
                    seq_next.state = ST_OFF_HOLD;
                end
            end
            default: begin
                seq_next = SEQ_RST;
            end
        endcase

        // software writes: refused while busy, in reset or initialising
        if (ser_go && ser_allowed && !seq_reg.ser_req && !seq_launch) begin
            seq_next.ser_req = 1'b1;
            seq_next.ser_addr = seq_reg.sw_addr;
            seq_next.ser_data = seq_reg.sw_data;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            seq_reg <= SEQ_RST;
        end else begin
            seq_reg <= seq_next;
        end
    end

    assign prdata_o = seq_reg.prdata;
    assign pready_o = seq_reg.pready;
    assign pslverr_o = seq_reg.pslverr;
    assign pll_supply_en_o = seq_reg.pll_en;
    assign pixel_supply_en_o = seq_reg.pix_en;
    assign core_supply_en_o = seq_reg.core_en;
    assign io_supply_en_o = seq_reg.io_en;
    assign ref_clock_in_en_o = seq_reg.clk_en;
    assign sensor_reset_n_o = seq_reg.rst_n;
    assign ser_req_o = seq_reg.ser_req;
    assign ser_addr_o = seq_reg.ser_addr;
    assign ser_data_o = seq_reg.ser_data;
endmodule : sensor_power_reset_sequencer

// ==== verification/seq_chk.sv ====
`timescale 1ns/1ps
module seq_chk
    import seq_pkg::*;
#(
    parameter int unsigned HARD_RESET_CYC = 20,
    parameter int unsigned INIT_WAIT_CYC = 30,
    parameter int unsigned OFF_HOLD_CYC = 50
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // power side
    input wire logic pll_supply_en_o,
    input wire logic pixel_supply_en_o,
    input wire logic core_supply_en_o,
    input wire logic io_supply_en_o,
    input wire logic supplies_stable_i,
    input wire logic ref_clock_in_en_o,
    input wire logic sensor_reset_n_o,
    // serial port
    input wire logic ser_req_o,
    input wire logic [15:0] ser_addr_o,
    input wire logic [15:0] ser_data_o,
    input wire logic ser_ack_i
);
    logic [11:0] pll_cnt, pix_cnt, core_cnt;
    logic [31:0] off_cnt;
    logic strm;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    // saturating age of the pll, pixel and core supplies, zero while off
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pll_cnt <= 12'h000;
            pix_cnt <= 12'h000;
            core_cnt <= 12'h000;
            off_cnt <= 32'h0;
            strm <= 1'b0;
        end else begin
            pll_cnt <= pll_supply_en_o ? pll_cnt + {11'h000, ~&pll_cnt} : 12'h000;
            pix_cnt <= pixel_supply_en_o ? pix_cnt + {11'h000, ~&pix_cnt} : 12'h000;
            core_cnt <= core_supply_en_o ? core_cnt + {11'h000, ~&core_cnt} : 12'h000;
            off_cnt <= pll_supply_en_o ? 32'h0 : off_cnt + 32'h1;
            if (ser_req_o && ser_ack_i && ser_addr_o == 16'h301A) begin
                strm <= ser_data_o[2];
            end
        end
    end
    chk_pix_step: assert property ($rose(pixel_supply_en_o) |-> pll_cnt <= 12'h190)
        else $error("pixel supply too late after pll supply");
    chk_core_step: assert property ($rose(core_supply_en_o) |-> pix_cnt <= 12'h190)
        else $error("core supply too late after pixel supply");
    chk_io_gap: assert property ($rose(io_supply_en_o) |-> core_cnt >= 12'h0C8 && core_cnt <= 12'h190)
        else $error("io supply gap after core supply wrong");
    chk_supply_prefix: assert property ({pll_supply_en_o, pixel_supply_en_o, core_supply_en_o,
        io_supply_en_o} inside {4'h0, 4'h8, 4'hC, 4'hE, 4'hF})
        else $error("supply enables out of order");
    chk_clk_stable: assert property ($rose(ref_clock_in_en_o) |-> io_supply_en_o && supplies_stable_i)
        else $error("reference clock started before supplies stable");
    chk_reset_hold: assert property ($rose(sensor_reset_n_o) |-> $past(ref_clock_in_en_o, HARD_RESET_CYC))
        else $error("hard reset released too early");
    chk_init_wait: assert property ($rose(ser_req_o) |-> sensor_reset_n_o
        && $past(sensor_reset_n_o, INIT_WAIT_CYC))
        else $error("serial write during reset or initialisation");
    chk_req_hold: assert property (ser_req_o && !ser_ack_i |=> ser_req_o && $stable(ser_addr_o)
        && $stable(ser_data_o))
        else $error("serial request changed before ack");
    chk_req_drop: assert property (ser_req_o && ser_ack_i |=> !ser_req_o)
        else $error("serial request held after ack");
    chk_stream_first: assert property ($fell(io_supply_en_o) |-> !strm)
        else $error("supply removed while streaming");
    chk_off_hold: assert property ($rose(pll_supply_en_o) |-> off_cnt >= OFF_HOLD_CYC)
        else $error("power-up too soon after power-down");
    cov_up: cover property ($rose(io_supply_en_o));
    cov_down: cover property ($fell(pll_supply_en_o));
    cov_stream: cover property (ser_req_o && ser_ack_i && ser_data_o[2]);
endmodule : seq_chk

// ==== verification/sensor_model.sv ====
`timescale 1ns/1ps
module sensor_model #(
    parameter int unsigned INIT_CYC = 30,
    parameter int unsigned ROW_CYC = 16
) (
    // power, clock and reset pins
    input wire logic ref_clk_i,
    input wire logic pll_en_i,
    input wire logic pix_en_i,
    input wire logic core_en_i,
    input wire logic io_en_i,
    input wire logic clk_en_i,
    input wire logic reset_n_i,
    output logic stable_o,
    // serial write port
    input wire logic req_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] data_i,
    input wire logic slow_i,
    output logic ack_o,
    // observation
    output logic [15:0] mode_o,
    output logic streaming_o,
    output logic [15:0] last_addr_o,
    output logic [15:0] last_data_o,
    output int early_o
);
    int init_cnt = 0;
    int wait_cnt = 0;
    int row_cnt = 0;
    initial begin
        stable_o = 1'b0;
        ack_o = 1'b0;
        mode_o = 16'h0000;
        streaming_o = 1'b0;
        early_o = 0;
    end
    always @(posedge ref_clk_i) begin
        // power good lags the last enable by one cycle
        stable_o <= pll_en_i && pix_en_i && core_en_i && io_en_i;
        ack_o <= 1'b0;
        row_cnt <= (row_cnt + 1) % ROW_CYC;
        if (req_i && (!reset_n_i || !clk_en_i || init_cnt < INIT_CYC)) early_o <= early_o + 1;
        if (!reset_n_i || !clk_en_i) begin
            init_cnt <= 0;
            mode_o <= 16'h0000;
            streaming_o <= 1'b0;
        end else if (init_cnt < INIT_CYC) begin
            init_cnt <= init_cnt + 1;
        end else begin
            if (req_i && !ack_o && wait_cnt >= (slow_i ? 9 : 0)) begin
                ack_o <= 1'b1;
                wait_cnt <= 0;
                last_addr_o <= addr_i;
                last_data_o <= data_i;
                if (addr_i == 16'h301A) mode_o <= data_i;
            end else if (req_i) begin
                wait_cnt <= wait_cnt + 1;
            end
            // standby only at a row boundary
            if (mode_o[2] || row_cnt == 0) streaming_o <= mode_o[2];
        end
    end
endmodule : sensor_model

// ==== verification/sensor_power_reset_sequencer_tb.sv ====
`timescale 1ns/1ps
`include "seq_consts.svh"
module sensor_power_reset_sequencer_tb;
    import seq_pkg::*;
    logic ref_clk_i = 1'b0, nrst_i = 1'b0, psel_i, penable_i, pwrite_i, slow;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, q, base;
    logic pready_o, pslverr_o, pll_supply_en_o, pixel_supply_en_o, core_supply_en_o, io_supply_en_o;
    logic supplies_stable_i, ref_clock_in_en_o, sensor_reset_n_o, ser_req_o, ser_ack_i, err, streaming;
    logic [15:0] ser_addr_o, ser_data_o, mode, last_addr, last_data, a, d;
    int early, n_mismatch = 0, total_checks = 0, cycles = 0, t0;
    sensor_power_reset_sequencer #(.HARD_RESET_CYC(20), .INIT_WAIT_CYC(30), .PLL_LOCK_CYC(20),
        .OFF_HOLD_CYC(50)) dut (.ref_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .pll_supply_en_o, .pixel_supply_en_o, .core_supply_en_o,
        .io_supply_en_o, .supplies_stable_i, .ref_clock_in_en_o, .sensor_reset_n_o, .ser_req_o,
        .ser_addr_o, .ser_data_o, .ser_ack_i);
    sensor_model #(.INIT_CYC(30), .ROW_CYC(16)) model (.ref_clk_i, .pll_en_i(pll_supply_en_o),
        .pix_en_i(pixel_supply_en_o), .core_en_i(core_supply_en_o), .io_en_i(io_supply_en_o),
        .clk_en_i(ref_clock_in_en_o), .reset_n_i(sensor_reset_n_o), .stable_o(supplies_stable_i),
        .req_i(ser_req_o), .addr_i(ser_addr_o), .data_i(ser_data_o), .slow_i(slow), .ack_o(ser_ack_i),
        .mode_o(mode), .streaming_o(streaming), .last_addr_o(last_addr), .last_data_o(last_data),
        .early_o(early));
    always #12.5 ref_clk_i = ~ref_clk_i;
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    // long counts are scaled down; run stays a few thousand cycles
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // expected mode control word with the stream bit forced
    function automatic logic [31:0] mode_word(input logic [31:0] b, input logic on);
        logic [31:0] m;
        m = 32'h1 << `STREAM_ON_BIT;
        return on ? (b | m) : (b & ~m);
    endfunction : mode_word
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd, output logic [31:0] rd);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= ad;
        pwdata_i <= wd;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        @(posedge ref_clk_i);
        while (pready_o !== 1'b1) @(posedge ref_clk_i);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask : apb
    task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
        logic [31:0] rd;
        apb(1'b1, ad, wd, rd);
    endtask : wr
    task automatic poll(input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        apb(1'b0, `OFS_STATUS, 32'h0, q);
        while ((q & m) !== v && n < 500) begin
            apb(1'b0, `OFS_STATUS, 32'h0, q);
            n++;
        end
        check(q & m, v);
    endtask : poll
    task automatic wait_sig(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 2000) begin
            @(posedge ref_clk_i);
            n++;
        end
        check({31'h0, s}, {31'h0, v});
    endtask : wait_sig
    initial begin
        void'($urandom(84911));
        {psel_i, penable_i, pwrite_i, slow} <= 4'h0;
        paddr_i <= 12'h000;
        pwdata_i <= 32'h0;
        repeat (2) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        @(posedge ref_clk_i);
        apb(1'b0, `OFS_STATUS, 32'h0, q);
        check(q, {27'h0, ST_OFF_HOLD});
        apb(1'b0, `OFS_STBY_WAIT, 32'h0, q);
        check(q, 32'h000F4240);
        apb(1'b0, `OFS_CMD, 32'h0, q);
        check(q, 32'h0);
        apb(1'b0, 12'h01C, 32'h0, q);
        check({q[30:0], err}, 32'h1);
        $display("register test done");
        base = $urandom & 32'h0000FFFB;
        wr(`OFS_MODE_BASE, base);
        apb(1'b0, `OFS_MODE_BASE, 32'h0, q);
        check(q, base);
        wr(`OFS_STBY_WAIT, 32'h28);
        wr(`OFS_CTRL, 32'h1);
        poll(32'h1F, {27'h0, ST_CONFIG});
        check({pll_supply_en_o, io_supply_en_o, ref_clock_in_en_o, sensor_reset_n_o}, 32'hF);
        for (int i = 0; i < 4; i++) begin
            a = {4'h1, 12'($urandom)};
            d = 16'($urandom);
            slow <= 1'($urandom);
            wr(`OFS_SER_ADDR, {16'h0, a});
            wr(`OFS_SER_DATA, {16'h0, d});
            wr(`OFS_CMD, 32'h1);
            poll(32'h100, 32'h0);
            check({last_addr, last_data}, {a, d});
        end
        $display("configuration test done");
        wr(`OFS_CMD, 32'h2);
        t0 = cycles;
        wr(`OFS_CTRL, 32'h3);
        wait_sig(ser_req_o, 1'b1);
        check(32'(cycles - t0 >= 20), 32'h1);
        poll(32'h200, 32'h200);
        check({16'h0, mode}, mode_word(base, 1'b1));
        check({31'h0, streaming}, 32'h1);
        wr(`OFS_CTRL, 32'h1);
        // back in ready only after the ack and the standby wait, so the row has ended
        poll(32'h21F, {27'h0, ST_READY});
        check({16'h0, mode}, mode_word(base, 1'b0));
        check({31'h0, streaming}, 32'h0);
        $display("stream test done");
        wr(`OFS_CTRL, 32'h3);
        poll(32'h200, 32'h200);
        wr(`OFS_CTRL, 32'h0);
        wait_sig(pll_supply_en_o, 1'b0);
        check({pixel_supply_en_o, core_supply_en_o, io_supply_en_o, ref_clock_in_en_o}, 32'h0);
        check(early, 32'h0);
        wr(`OFS_CTRL, 32'h1);
        wait_sig(io_supply_en_o, 1'b1);
        $display("power cycle test done");
        end_of_test();
    end
endmodule : sensor_power_reset_sequencer_tb
bind sensor_power_reset_sequencer seq_chk #(.HARD_RESET_CYC(HARD_RESET_CYC), .INIT_WAIT_CYC(INIT_WAIT_CYC),
    .OFF_HOLD_CYC(OFF_HOLD_CYC)) chk (.ref_clk_i, .nrst_i, .pll_supply_en_o, .pixel_supply_en_o,
    .core_supply_en_o, .io_supply_en_o, .supplies_stable_i, .ref_clock_in_en_o, .sensor_reset_n_o,
    .ser_req_o, .ser_addr_o, .ser_data_o, .ser_ack_i);
